// ==== inc/bsci_pkg.sv ====
// package: constants and types of the serial command interpreter
package bsci_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int REPLY_MS = 5;
  localparam int REPLY_CYC = CLK_HZ / 1000 * REPLY_MS;
  // ---------------------------------------------------------------
  // sizes, characters, reset values
  // ---------------------------------------------------------------
  localparam int CMD_LEN = 80;
  localparam int FIFO_DEPTH = 16;
  localparam int MSG_LAST = 9;
  localparam logic [6:0] CH_D = 7'h44;
  localparam logic [6:0] CH_SP = 7'h20;
  localparam logic [6:0] CH_CR = 7'h0d;
  localparam logic [6:0] CH_LF = 7'h0a;
  localparam logic [6:0] CH_BS = 7'h08;
  localparam logic [6:0] CH_0 = 7'h30;
  localparam logic [6:0] CH_COLON = 7'h3a;
  localparam logic [31:0] VAL_RST = 32'h0;
  // ---------------------------------------------------------------
  // command letter pairs
  // ---------------------------------------------------------------
  localparam logic [13:0] READ_COUNT_CMD = {7'h44, 7'h43};
  localparam logic [13:0] READ_FLOW_SPEED_CMD = {7'h44, 7'h52};
  localparam logic [13:0] READ_GRAND_TOTAL_CMD = {7'h44, 7'h54};
  localparam logic [13:0] START_BATCH_CMD = {7'h47, 7'h4f};
  localparam logic [13:0] HALT_BATCH_CMD = {7'h53, 7'h54};
  localparam logic [13:0] COUNT_SCALE_CMD = {7'h4b, 7'h43};
  localparam logic [13:0] FLOW_SPEED_SCALE_CMD = {7'h4b, 7'h52};
  localparam logic [13:0] SETPOINT_CMD = {7'h50, 7'h41};
  localparam logic [13:0] EARLY_WARNING_CMD = {7'h50, 7'h57};
  localparam logic [13:0] CLEAR_COUNTER_CMD = {7'h52, 7'h43};
  localparam logic [13:0] CLEAR_TOTAL_CMD = {7'h52, 7'h54};
  // ---------------------------------------------------------------
  // value selectors (strobe codes)
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_PRESET = 3'h0;
  localparam logic [2:0] SEL_PREWARN = 3'h1;
  localparam logic [2:0] SEL_COUNT_K = 3'h2;
  localparam logic [2:0] SEL_RATE_K = 3'h3;
  localparam logic [2:0] SEL_COUNT = 3'h4;
  localparam logic [2:0] SEL_TOTAL = 3'h5;
  localparam logic [2:0] SEL_RATE = 3'h6;
  localparam logic [2:0] SEL_NONE = 3'h7;
  typedef enum logic [1:0] {PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE} bsci_par_t;
  typedef enum logic [3:0] {ST_OFF, ST_ANN, ST_COLLECT, ST_TOK, ST_AFT, ST_NUM, ST_EXEC, ST_EMIT,
                            ST_DRAIN} bsci_state_t;
endpackage

// ==== rtl/bsci_fifo.sv ====
// file: small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module bsci_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== rtl/bsci_top.sv ====
// file: serial command interpreter of the batch controller
`timescale 1ns/1ps
module bsci_top #(
  parameter int BIT_CYC = bsci_pkg::BIT_CYC,
  parameter int REPLY_CYC = bsci_pkg::REPLY_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic rx_in,
  output logic tx_out_q,
  output logic tx_oe_q,
  input wire logic [3:0] unit_code,
  input wire bsci_pkg::bsci_par_t parity_sel,
  input wire logic strobe,
  input wire logic req_code_bit0,
  input wire logic req_code_bit1,
  input wire logic req_code_bit2,
  input wire logic adding_mode,
  input wire logic keypad_event,
  input wire logic signal_event,
  input wire logic [31:0] count_bcd,
  input wire logic [31:0] rate_bcd,
  input wire logic [31:0] total_bcd,
  output logic [31:0] preset_q,
  output logic [31:0] prewarn_q,
  output logic [31:0] count_scale_q,
  output logic [31:0] rate_scale_q,
  output logic counter_load_q,
  output logic [31:0] counter_val_q,
  output logic total_load_q,
  output logic [31:0] total_val_q,
  output logic batch_start_q,
  output logic batch_halt_q,
  output logic output_reset_q,
  output logic on_line_q
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] sel_value(input logic [2:0] s);
    case (s)
      bsci_pkg::SEL_PRESET: sel_value = preset_q;
      bsci_pkg::SEL_PREWARN: sel_value = prewarn_q;
      bsci_pkg::SEL_COUNT_K: sel_value = count_scale_q;
      bsci_pkg::SEL_RATE_K: sel_value = rate_scale_q;
      bsci_pkg::SEL_COUNT: sel_value = count_bcd;
      bsci_pkg::SEL_TOTAL: sel_value = total_bcd;
      default: sel_value = rate_bcd;
    endcase
  endfunction
  function automatic logic [2:0] read_sel(input logic [13:0] t);
    case (t)
      bsci_pkg::SETPOINT_CMD: read_sel = bsci_pkg::SEL_PRESET;
      bsci_pkg::EARLY_WARNING_CMD: read_sel = bsci_pkg::SEL_PREWARN;
      bsci_pkg::COUNT_SCALE_CMD: read_sel = bsci_pkg::SEL_COUNT_K;
      bsci_pkg::FLOW_SPEED_SCALE_CMD: read_sel = bsci_pkg::SEL_RATE_K;
      bsci_pkg::READ_COUNT_CMD: read_sel = bsci_pkg::SEL_COUNT;
      bsci_pkg::READ_GRAND_TOTAL_CMD: read_sel = bsci_pkg::SEL_TOTAL;
      bsci_pkg::READ_FLOW_SPEED_CMD: read_sel = bsci_pkg::SEL_RATE;
      default: read_sel = bsci_pkg::SEL_NONE;
    endcase
  endfunction
  function automatic logic is_digit(input logic [6:0] c);
    is_digit = c >= bsci_pkg::CH_0 && c <= 7'h39;
  endfunction
  // ---------------------------------------------------------------
  // receiver: 7 data bits, parity skipped
  // ---------------------------------------------------------------
  logic rx_busy_q, rx_valid_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [6:0] rx_sh_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_busy_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
    end else begin
      rx_valid_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_in) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= 16'(BIT_CYC / 2);
          rx_bit_q <= '0;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= 16'(BIT_CYC - 1);
        rx_bit_q <= rx_bit_q + 1'b1;
        if (rx_bit_q == 4'h0 && rx_in) rx_busy_q <= 1'b0;
        if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h7) rx_sh_q <= {rx_in, rx_sh_q[6:1]};
        if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_valid_q <= 1'b1;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // transmit fifo and transmitter
  // ---------------------------------------------------------------
  logic push_v, in_ready, out_valid, tx_busy_q;
  logic [6:0] push_d, out_data;
  logic [9:0] tx_sh_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic par;
  bsci_fifo #(.WIDTH(7), .DEPTH(bsci_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk), .reset(reset), .in_valid(push_v), .in_ready(in_ready), .in_data(push_d),
    .out_valid(out_valid), .out_ready(!tx_busy_q), .out_data(out_data));
  always_comb begin
    case (parity_sel)
      bsci_pkg::PAR_ODD: par = ~(^out_data);
      bsci_pkg::PAR_EVEN: par = ^out_data;
      bsci_pkg::PAR_MARK: par = 1'b1;
      default: par = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= '1;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_out_q <= 1'b1;
    end else if (!tx_busy_q) begin
      tx_out_q <= 1'b1;
      if (out_valid) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, par, out_data, 1'b0};
        tx_cnt_q <= 16'(BIT_CYC - 1);
        tx_bit_q <= '0;
      end
    end else begin
      tx_out_q <= tx_sh_q[0];
      if (tx_cnt_q != '0) begin
        tx_cnt_q <= tx_cnt_q - 1'b1;
      end else begin
        tx_cnt_q <= 16'(BIT_CYC - 1);
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 1'b1;
        if (tx_bit_q == 4'h9) tx_busy_q <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // command state machine
  // ---------------------------------------------------------------
  bsci_pkg::bsci_state_t st_q, ret_q;
  logic [6:0] cbuf [bsci_pkg::CMD_LEN];
  logic [6:0] len_q, idx_q, cur;
  logic [1:0] addr_st_q, tok_n_q;
  logic [4:0] addr_q;
  logic [13:0] tok_q;
  logic [31:0] num_q, val_q;
  logic [3:0] n_q;
  logic ann_q, has_num_q, strobe_q, at_end, halt, strobe_rise;
  logic [2:0] req_code;
  assign req_code = {req_code_bit2, req_code_bit1, req_code_bit0};
  assign strobe_rise = strobe && !strobe_q;
  assign cur = cbuf[idx_q];
  assign at_end = idx_q == len_q;
  assign halt = keypad_event || signal_event || rx_valid_q;
  always_comb begin
    push_v = 1'b0;
    push_d = rx_sh_q;
    if (st_q == bsci_pkg::ST_COLLECT) begin
      push_v = rx_valid_q;
    end else if (st_q == bsci_pkg::ST_EMIT) begin
      push_v = 1'b1;
      if (ann_q) begin
        case (n_q)
          4'h0: push_d = bsci_pkg::CH_D;
          4'h1: push_d = 7'h65;
          4'h2: push_d = 7'h76;
          4'h3: push_d = 7'h69;
          4'h4: push_d = 7'h63;
          4'h5: push_d = 7'h65;
          4'h6: push_d = bsci_pkg::CH_SP;
          4'h7: push_d = bsci_pkg::CH_0 + 7'(unit_code >= 4'ha);
          4'h8: push_d = bsci_pkg::CH_0 + 7'(unit_code >= 4'ha ? unit_code - 4'ha : unit_code);
          default: push_d = bsci_pkg::CH_COLON;
        endcase
      end else if (n_q == 4'h0) begin
        push_d = bsci_pkg::CH_CR;
      end else if (n_q == 4'h1) begin
        push_d = bsci_pkg::CH_LF;
      end else begin
        push_d = bsci_pkg::CH_0 + 7'(val_q[31:28]);
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (st_q == bsci_pkg::ST_COLLECT && rx_valid_q && rx_sh_q != bsci_pkg::CH_BS
        && rx_sh_q != bsci_pkg::CH_CR && len_q != 7'(bsci_pkg::CMD_LEN)) begin
      cbuf[len_q] <= rx_sh_q;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= bsci_pkg::ST_OFF;
      ret_q <= bsci_pkg::ST_OFF;
      {len_q, idx_q, addr_st_q, tok_n_q, addr_q, tok_q, n_q} <= '0;
      {num_q, val_q, ann_q, has_num_q, strobe_q, on_line_q} <= '0;
    end else begin
      strobe_q <= strobe;
      case (st_q)
        bsci_pkg::ST_OFF: begin
          if (strobe_rise && req_code != bsci_pkg::SEL_NONE) begin
            on_line_q <= 1'b1;
            val_q <= sel_value(req_code);
            {ann_q, n_q} <= '0;
            st_q <= bsci_pkg::ST_EMIT;
            ret_q <= bsci_pkg::ST_DRAIN;
          end else if (rx_valid_q) begin
            addr_st_q <= '0;
            if (rx_sh_q == bsci_pkg::CH_D) begin
              addr_st_q <= 2'h1;
              addr_q <= '0;
            end else if (addr_st_q != 2'h0 && is_digit(rx_sh_q) && addr_q < 5'h10) begin
              addr_st_q <= 2'h2;
              addr_q <= 5'(addr_q * 10 + 5'(rx_sh_q[3:0]));
            end else if (addr_st_q == 2'h2 && rx_sh_q == bsci_pkg::CH_SP && addr_q == {1'b0, unit_code}) begin
              on_line_q <= 1'b1;
              {ann_q, n_q} <= {1'b1, 4'h0};
              len_q <= '0;
              st_q <= bsci_pkg::ST_EMIT;
              ret_q <= bsci_pkg::ST_COLLECT;
            end
          end
        end
        bsci_pkg::ST_COLLECT: begin
          if (rx_valid_q) begin
            if (rx_sh_q == bsci_pkg::CH_CR) begin
              {idx_q, tok_n_q} <= '0;
              st_q <= bsci_pkg::ST_TOK;
            end else if (rx_sh_q == bsci_pkg::CH_BS) begin
              if (len_q != '0) len_q <= len_q - 1'b1;
            end else if (len_q != 7'(bsci_pkg::CMD_LEN)) begin
              len_q <= len_q + 1'b1;
            end
          end
        end
        bsci_pkg::ST_TOK: begin
          if (at_end) begin
            has_num_q <= 1'b0;
            st_q <= (tok_n_q == 2'h2) ? bsci_pkg::ST_EXEC : bsci_pkg::ST_DRAIN;
          end else begin
            idx_q <= idx_q + 1'b1;
            if (cur == bsci_pkg::CH_SP) begin
              if (tok_n_q == 2'h2) st_q <= bsci_pkg::ST_AFT;
            end else begin
              tok_q <= {tok_q[6:0], cur};
              if (tok_n_q != 2'h2) tok_n_q <= tok_n_q + 1'b1;
            end
          end
        end
        bsci_pkg::ST_AFT: begin
          num_q <= '0;
          has_num_q <= !at_end && is_digit(cur);
          st_q <= (!at_end && is_digit(cur)) ? bsci_pkg::ST_NUM : bsci_pkg::ST_EXEC;
        end
        bsci_pkg::ST_NUM: begin
          if (!at_end && is_digit(cur)) begin
            num_q <= {num_q[27:0], cur[3:0]};
            idx_q <= idx_q + 1'b1;
          end else begin
            st_q <= bsci_pkg::ST_EXEC;
          end
        end
        bsci_pkg::ST_EXEC: begin
          tok_n_q <= '0;
          st_q <= bsci_pkg::ST_TOK;
          if (!has_num_q && read_sel(tok_q) != bsci_pkg::SEL_NONE) begin
            val_q <= sel_value(read_sel(tok_q));
            {ann_q, n_q} <= '0;
            st_q <= bsci_pkg::ST_EMIT;
            ret_q <= bsci_pkg::ST_TOK;
          end
        end
        bsci_pkg::ST_EMIT: begin
          if (in_ready) begin
            n_q <= n_q + 1'b1;
            if (!ann_q && n_q >= 4'h2) val_q <= {val_q[27:0], 4'h0};
            if (n_q == 4'(bsci_pkg::MSG_LAST)) st_q <= ret_q;
          end
        end
        bsci_pkg::ST_DRAIN: begin
          if (!out_valid && !tx_busy_q) begin
            on_line_q <= 1'b0;
            addr_st_q <= '0;
            st_q <= bsci_pkg::ST_OFF;
          end
        end
        default: st_q <= bsci_pkg::ST_OFF;
      endcase
      if (halt && st_q inside {bsci_pkg::ST_TOK, bsci_pkg::ST_AFT, bsci_pkg::ST_NUM, bsci_pkg::ST_EXEC}
          || halt && st_q == bsci_pkg::ST_EMIT && !ann_q) begin
        st_q <= bsci_pkg::ST_DRAIN;
      end
    end
  end
  // ---------------------------------------------------------------
  // stored values, command pulses, line driver
  // ---------------------------------------------------------------
  logic do_exec;
  assign do_exec = st_q == bsci_pkg::ST_EXEC && !halt;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {preset_q, prewarn_q, count_scale_q, rate_scale_q} <= {4{bsci_pkg::VAL_RST}};
      {counter_val_q, total_val_q} <= '0;
      {counter_load_q, total_load_q, batch_start_q, batch_halt_q, output_reset_q, tx_oe_q} <= '0;
    end else begin
      tx_oe_q <= unit_code == 4'h0 || on_line_q;
      {counter_load_q, total_load_q, batch_start_q, batch_halt_q, output_reset_q} <= '0;
      if (do_exec) begin
        case (tok_q)
          bsci_pkg::SETPOINT_CMD: if (has_num_q) preset_q <= num_q;
          bsci_pkg::EARLY_WARNING_CMD: if (has_num_q) prewarn_q <= num_q;
          bsci_pkg::COUNT_SCALE_CMD: if (has_num_q) count_scale_q <= num_q;
          bsci_pkg::FLOW_SPEED_SCALE_CMD: if (has_num_q) rate_scale_q <= num_q;
          bsci_pkg::START_BATCH_CMD: batch_start_q <= 1'b1;
          bsci_pkg::HALT_BATCH_CMD: batch_halt_q <= 1'b1;
          bsci_pkg::CLEAR_COUNTER_CMD: begin
            counter_load_q <= 1'b1;
            counter_val_q <= has_num_q ? num_q : (adding_mode ? '0 : preset_q);
            output_reset_q <= !has_num_q;
          end
          bsci_pkg::CLEAR_TOTAL_CMD: begin
            total_load_q <= 1'b1;
            total_val_q <= has_num_q ? num_q : '0;
          end
          default: ;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [17:0] wait_q;
  logic proc;
  assign proc = st_q inside {bsci_pkg::ST_TOK, bsci_pkg::ST_AFT, bsci_pkg::ST_NUM, bsci_pkg::ST_EXEC};
  always_ff @(posedge core_clk) begin
    if (reset || !proc) wait_q <= '0;
    else wait_q <= wait_q + 1'b1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_echo_char: assert property (st_q == bsci_pkg::ST_COLLECT && rx_valid_q && in_ready |=> out_valid)
    else $error("received character not echoed");
  chk_buf_limit: assert property (len_q <= 7'(bsci_pkg::CMD_LEN))
    else $error("command buffer overrun");
  chk_backspace: assert property (st_q == bsci_pkg::ST_COLLECT && rx_valid_q && rx_sh_q == bsci_pkg::CH_BS
      && len_q != '0 |=> len_q == $past(len_q) - 7'h1)
    else $error("backspace did not remove a character");
  chk_cr_start: assert property (st_q == bsci_pkg::ST_COLLECT && rx_valid_q && rx_sh_q == bsci_pkg::CH_CR
      |=> st_q == bsci_pkg::ST_TOK)
    else $error("carriage return did not start processing");
  chk_crlf_lead: assert property (st_q == bsci_pkg::ST_EMIT && !ann_q && n_q == 4'h0 |-> push_d == bsci_pkg::CH_CR)
    else $error("value not led by CR");
  chk_lf_follow: assert property (st_q == bsci_pkg::ST_EMIT && !ann_q && n_q == 4'h0 && in_ready && !halt
      |=> st_q == bsci_pkg::ST_EMIT && n_q == 4'h1 && push_d == bsci_pkg::CH_LF)
    else $error("CR not followed by LF");
  chk_halt_event: assert property (proc && keypad_event |=> st_q == bsci_pkg::ST_DRAIN)
    else $error("keypad event did not halt the cycle");
  chk_off_line: assert property (st_q == bsci_pkg::ST_DRAIN && !out_valid && !tx_busy_q
      |=> !on_line_q ##1 !tx_oe_q || unit_code == 4'h0)
    else $error("unit stayed on line after replies");
  chk_proc_time: assert property (wait_q < 18'(REPLY_CYC))
    else $error("request processing too slow");
  chk_strobe_tx: assert property (st_q == bsci_pkg::ST_OFF && strobe_rise && req_code != bsci_pkg::SEL_NONE
      && !tx_busy_q |-> ##[1:20] tx_busy_q)
    else $error("strobe reply did not start");
  chk_discard_off: assert property (st_q == bsci_pkg::ST_OFF |-> !push_v)
    else $error("character answered while off line");
  cov_address: cover property (st_q == bsci_pkg::ST_ANN || (st_q == bsci_pkg::ST_EMIT && ann_q));
  cov_read_reply: cover property (st_q == bsci_pkg::ST_EXEC ##1 st_q == bsci_pkg::ST_EMIT);
  cov_counter_reset: cover property (output_reset_q);
endmodule

// ==== dv/bsci_term_model.sv ====
// terminal model: serial sender and receiver facing the interpreter
`timescale 1ns/1ps
module bsci_term_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic core_clk,
  output logic rx_in,
  input wire logic tx_out_q,
  input wire logic tx_oe_q
);
  // ----------------------------------------
  // line, sender, receiver
  // ----------------------------------------
  logic line;
  logic [7:0] sh;
  logic [7:0] got_q[$];
  // a released line floats to the pull-up level
  assign line = tx_oe_q ? tx_out_q : 1'b1;
  initial rx_in = 1'b1;
  // sends one string, each char framed as start, 7 data bits, parity 0, stop
  task automatic send_str(input string s);
    logic [9:0] fr;
    for (int c = 0; c < s.len(); c++) begin
      fr = {2'b10, 7'(s[c]), 1'b0};
      for (int i = 0; i < 10; i++) begin
        @(negedge core_clk);
        rx_in = fr[i];
        repeat (BIT_CYC - 1) @(negedge core_clk);
      end
    end
  endtask
  // keeps parity beside the data so the bench can judge it
  always begin
    @(posedge core_clk);
    if (line === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        sh[i] = line;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      got_q.push_back(sh);
    end
  end
endmodule

// ==== dv/tb_bsci_top.sv ====
// testbench of the serial command interpreter
`timescale 1ns/1ps
module tb_bsci_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic rx_in, tx_out_q, tx_oe_q, strobe, b0, b1, b2, on_line_q, batch_start_q, output_reset_q;
  logic adding_mode, keypad_event, signal_event;
  logic [3:0] unit_code;
  logic [31:0] preset_q, counter_val_q, total_val_q, count_bcd;
  bsci_pkg::bsci_par_t parity_sel;
  int fails = 0;
  int total_checks = 0;
  int starts = 0;
  int resets = 0;
  string cmd = "PA 12X\0103 RC 42 GO PA\015";
  string exp_txt[7] = '{"00000123", "00000000", "00000000", "00000000", "12345678", "00987654", "00000456"};
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (batch_start_q === 1'b1) starts <= starts + 1;
  always @(posedge core_clk) if (output_reset_q === 1'b1) resets <= resets + 1;
  // ----------------------------------------
  // design and terminal
  // ----------------------------------------
  bsci_top #(.BIT_CYC(8), .REPLY_CYC(200)) u_bsci_top (.core_clk(core_clk), .reset(reset), .rx_in(rx_in),
    .tx_out_q(tx_out_q), .tx_oe_q(tx_oe_q), .unit_code(unit_code), .parity_sel(parity_sel), .strobe(strobe),
    .req_code_bit0(b0), .req_code_bit1(b1), .req_code_bit2(b2), .adding_mode(adding_mode),
    .keypad_event(keypad_event), .signal_event(signal_event), .count_bcd(count_bcd), .rate_bcd(32'h00000456),
    .total_bcd(32'h00987654), .preset_q(preset_q), .prewarn_q(), .count_scale_q(), .rate_scale_q(),
    .counter_load_q(), .counter_val_q(counter_val_q), .total_load_q(), .total_val_q(total_val_q),
    .batch_start_q(batch_start_q), .batch_halt_q(), .output_reset_q(output_reset_q), .on_line_q(on_line_q));
  bsci_term_model #(.BIT_CYC(8)) u_bsci_term_model (.core_clk(core_clk), .rx_in(rx_in), .tx_out_q(tx_out_q),
    .tx_oe_q(tx_oe_q));
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_chr(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic par_of(input logic [6:0] c);
    case (parity_sel)
      bsci_pkg::PAR_ODD: return ~^c;
      bsci_pkg::PAR_EVEN: return ^c;
      bsci_pkg::PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // 400 cycles covers the reply bound plus one frame
  task automatic expect_str(input string s);
    logic [7:0] g;
    logic [6:0] c;
    for (int i = 0; i < s.len(); i++) begin
      g = 8'hff;
      c = 7'(s[i]);
      for (int w = 0; w < 400 && u_bsci_term_model.got_q.size() == 0; w++) @(posedge core_clk);
      if (u_bsci_term_model.got_q.size() != 0) g = u_bsci_term_model.got_q.pop_front();
      check_chr(g, {par_of(c), c});
    end
  endtask
  task automatic wait_off();
    for (int w = 0; w < 2000 && on_line_q !== 1'b0; w++) @(negedge core_clk);
    check_val({31'h0, on_line_q}, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    conclude();
  end
  initial begin
    {strobe, b0, b1, b2, keypad_event, signal_event} = 6'h0;
    unit_code = 4'h5;
    adding_mode = 1'b1;
    count_bcd = 32'h12345678;
    parity_sel = bsci_pkg::PAR_EVEN;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    check_val({31'h0, tx_oe_q}, 32'h0);
    u_bsci_term_model.send_str("D3 ");
    repeat (300) @(negedge core_clk);
    check_val({31'h0, tx_oe_q}, 32'h0);
    check_val(32'(u_bsci_term_model.got_q.size()), 32'h0);
    $display("test foreign address done");
    u_bsci_term_model.send_str("D5 ");
    expect_str("Device 05:");
    u_bsci_term_model.send_str(cmd);
    expect_str(cmd);
    expect_str({"\015\012", exp_txt[0]});
    wait_off();
    check_val(preset_q, 32'h00000123);
    check_val(counter_val_q, 32'h00000042);
    check_val(32'(starts), 32'h1);
    $display("test serial session done");
    adding_mode = 1'b0;
    u_bsci_term_model.send_str("D5 ");
    expect_str("Device 05:");
    u_bsci_term_model.send_str("RC RT 376 DC\015");
    expect_str({"RC RT 376 DC\015\015\012", "12345678"});
    wait_off();
    check_val(counter_val_q, 32'h00000123);
    check_val(32'(resets), 32'h1);
    check_val(total_val_q, 32'h00000376);
    $display("test subtracting reset done");
    for (int h = 0; h < 2; h++) begin
      u_bsci_term_model.send_str("D5 ");
      expect_str("Device 05:");
      @(negedge core_clk);
      {signal_event, keypad_event} = 2'(h + 1);
      u_bsci_term_model.send_str("DC\015");
      expect_str("DC\015");
      wait_off();
      check_val(32'(u_bsci_term_model.got_q.size()), 32'h0);
      {signal_event, keypad_event} = 2'h0;
    end
    $display("test halt events done");
    for (int k = 0; k < 7; k++) begin
      parity_sel = bsci_pkg::bsci_par_t'(k % 4);
      {b2, b1, b0} = 3'(k);
      @(negedge core_clk);
      strobe = 1'b1;
      repeat (20) @(negedge core_clk);
      strobe = 1'b0;
      expect_str({"\015\012", exp_txt[k]});
      wait_off();
    end
    $display("test strobe codes done");
    unit_code = 4'h0;
    repeat (2) @(negedge core_clk);
    check_val({31'h0, tx_oe_q}, 32'h1);
    $display("test dedicated unit done");
    conclude();
  end
endmodule
